// *** tmr18_consts.svh ***
`ifndef TMR18_CONSTS_SVH
`define TMR18_CONSTS_SVH
// Overview of operation
// - Timer mode: count ticks, match interrupts, clears
// - Source clock choice depends on power mode
// - Slow mode undivided clock matches top 7 bits
// - Event mode: count falling edges, match clears
// - Pulse width: count falls of event AND clock
// - Window edge interrupt: falling or both edges
// - Measurement count keeps value until cleared
// - Wrap to zero sets sticky overflow flag
// - Stopping while event high raises interrupt
// - Both-edge start while event high interrupts
// - Gate-active flag meaningless in pulse width
// - Event fall during clock high adds one
// - Frequency mode counts events while gate high
// - Gate-active flag follows window in frequency
// - Output block control gates companion output
// - Gate high time is (16-setting) base periods
// - Separate high and low period settings
// - Gate syncs to divider, may start late
// - Low setting takes effect next low period
// - Gate fall while event high adds one
// - Gate-active reads 1 only counting high period
`define OFF_CTRL1     5'h00
`define OFF_CTRL2     5'h04
`define OFF_COMPARE   5'h08
`define OFF_GATE      5'h0C
`define OFF_STATUS    5'h10
`define OFF_COUNT     5'h14
`define CLEAR_BIT     7
`define STAT_GATE_BIT 7
`define STAT_OVF_BIT  6
`define START_RUN     2'h2
`define CNT_MAX       18'h3FFFF
`define GATE_FULL     5'h10
`define LF_DIV        11'h5F6
`define CMP_RST       18'h00000
`define GATE_RST      8'h00
`endif

// *** tmr18_pkg.sv ***
package tmr18_pkg;
   // System power modes
   typedef enum logic [1:0] {PWR_NORMAL, PWR_IDLE, PWR_SLOW, PWR_SLEEP} pwr_mode_e;
   // Counter operating modes
   typedef enum logic [1:0] {MD_TIMER, MD_EVENT, MD_PULSE, MD_FREQ} tmr_mode_e;
   // Window gate sequencer states
   typedef enum logic [1:0] {GW_IDLE, GW_WAIT, GW_HIGH, GW_LOW} gate_st_e;
endpackage

// *** window_gate_gen.sv ***
`timescale 1ns/1ps
`include "tmr18_consts.svh"
module window_gate_gen (
   input  wire logic       i_clk,      // System clock
   input  wire logic       i_srst,     // Sync reset
   input  wire logic       i_run,      // Timer running
   input  wire logic       i_tick,     // Base period tick
   input  wire logic [3:0] i_high_set, // High period setting
   input  wire logic [3:0] i_low_set,  // Low period setting
   output logic            o_gate      // Window level
);
   import tmr18_pkg::*;

   gate_st_e   st_r;   // Sequencer state
   gate_st_e   st_nxt; // Next state
   logic [4:0] left_r; // Ticks left in phase
   logic [4:0] left_nxt;
   wire        last = (left_r == 5'h01); // Phase ends this tick

   // Period length in base ticks
   function automatic logic [4:0] span(input logic [3:0] s);
      span = 5'(`GATE_FULL - {1'b0, s});
   endfunction

   // Phase sequencing
   always_comb begin
      st_nxt   = st_r;
      left_nxt = left_r;
      unique case (st_r)
         GW_IDLE: if (i_run) st_nxt = GW_WAIT;
         GW_WAIT: if (i_tick) begin // First phase waits a divider tick
            st_nxt   = GW_HIGH;
            left_nxt = span(i_high_set);
         end
         GW_HIGH: if (i_tick) begin
            left_nxt = left_r - 5'h01;
            if (last) begin // Low value latched at low entry
               st_nxt   = GW_LOW;
               left_nxt = span(i_low_set);
            end
         end
         GW_LOW: if (i_tick) begin
            left_nxt = left_r - 5'h01;
            if (last) begin // Cycle is high plus low
               st_nxt   = GW_HIGH;
               left_nxt = span(i_high_set);
            end
         end
      endcase
      if (!i_run) st_nxt = GW_IDLE;
   end

   // State registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_r   <= GW_IDLE;
         left_r <= 5'h00;
      end else begin
         st_r   <= st_nxt;
         left_r <= left_nxt;
      end
   end

   assign o_gate = (st_r == GW_HIGH);
endmodule

// *** eighteen_bit_multimode_timer.sv ***
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "tmr18_consts.svh"
module eighteen_bit_multimode_timer (
   input  wire logic                 I_CLK_SYS,                // 50 MHz clock
   input  wire logic                 I_SRST,                   // Sync reset, high
   input  wire logic [4:0]           I_AVS_ADDRESS,            // Byte address
   input  wire logic                 I_AVS_READ,               // Read request
   input  wire logic                 I_AVS_WRITE,              // Write request
   input  wire logic [31:0]          I_AVS_WRITEDATA,          // Write data
   output logic      [31:0]          O_AVS_READDATA,           // Read data
   output logic                      O_AVS_WAITREQUEST,        // Wait request
   input  wire tmr18_pkg::pwr_mode_e I_PWR_MODE,               // Power mode
   input  wire logic                 I_EVENT_INPUT_PIN,        // Event pin
   input  wire logic                 I_EXTERNAL_GATE_INPUT,    // External gate
   input  wire logic                 I_COMPANION_TIMER_OUTPUT, // Companion out
   output logic                      O_SHARED_OUTPUT_PIN,      // Shared pin
   output logic                      O_SHARED_OUTPUT_OE,       // Shared pin enable
   output logic                      O_TIMER_INTERRUPT         // Interrupt pulse
);
   import tmr18_pkg::*;

   // Control fields
   tmr_mode_e   mode_r;      // Operating mode
   logic [1:0]  start_r;     // Start control
   logic [2:0]  src_r;       // Source clock select
   logic        edge_r;      // Gate edge select
   logic [1:0]  gsrc_r;      // Gate source select
   logic [1:0]  gclk_r;      // Gate clock select
   logic        oblk_r;      // Companion output block
   logic        dvs_r;       // Divider stage select
   logic [17:0] cmp_r;       // Compare value
   logic [7:0]  gper_r;      // Gate period setting
   // Counter state
   logic [17:0] cnt_r;       // Up counter
   logic [17:0] cnt_nxt;
   logic        ovf_r;       // Overflow flag
   logic        ovf_nxt;
   logic        gact_r;      // Gate active flag
   // Dividers
   logic [22:0] hf_r;        // High clock divider
   logic [10:0] lfp_r;       // Low clock prescaler
   logic [14:0] lf_r;        // Low clock divider
   logic        lfen_r;      // Low clock enable
   // Input pipeline
   logic        ev_m_r;      // Event sync stage 1
   logic        ev_s_r;      // Event sync stage 2
   logic        ev_d_r;      // Event delayed
   logic        and_d_r;     // AND window delayed
   logic        win_d_r;     // Window delayed
   // Bus
   logic        wait_r;      // Wait request
   logic [31:0] rdata_r;     // Read data
   logic        irq_r;       // Interrupt pulse
   logic        shp_r;       // Shared pin value
   logic        oe_r;        // Shared pin enable

   // Divider tap: all low bits set
   function automatic logic taps(input logic [22:0] c, input int n);
      logic r;
      r = 1'b1;
      for (int i = 0; i < 23; i++) begin
         if (i < n) r = r & c[i];
      end
      taps = r;
   endfunction

   // Power mode decode
   wire slow  = (I_PWR_MODE == PWR_SLOW);
   wire sleep = (I_PWR_MODE == PWR_SLEEP);
   wire lowpw = slow | sleep;
   wire use_lf = dvs_r | lowpw;
   wire [22:0] lfx = {8'h00, lf_r};

   // Divider tick pulses
   wire fc23 = taps(hf_r, 23);
   wire fc13 = taps(hf_r, 13);
   wire fc11 = taps(hf_r, 11);
   wire fc7  = taps(hf_r, 7);
   wire fc3  = taps(hf_r, 3);
   wire fs15 = lfen_r & taps(lfx, 15);
   wire fs5  = lfen_r & taps(lfx, 5);
   wire fs3  = lfen_r & taps(lfx, 3);
   wire fs4  = lfen_r & taps(lfx, 4);
   wire fs6  = lfen_r & taps(lfx, 6);
   wire fc12 = taps(hf_r, 12);
   wire fc14 = taps(hf_r, 14);

   // Internal source tick selection
   wire src_tick =
      (src_r == 3'h0) ? (use_lf ? fs15 : fc23) :
      (src_r == 3'h1) ? (use_lf ? fs5 : fc13) :
      (src_r == 3'h2) ? (use_lf ? fs3 : fc11) :
      (src_r == 3'h3) ? (!lowpw & fc7) :
      (src_r == 3'h4) ? (!lowpw & fc3) :
      (src_r == 3'h5) ? (!lowpw & lfen_r) :
      (src_r == 3'h6) ? !sleep : 1'b0;
   // Internal source level, falls at each tick (source 6: at every other tick)
   wire src_lvl =
      (src_r == 3'h0) ? (use_lf ? lf_r[14] : hf_r[22]) :
      (src_r == 3'h1) ? (use_lf ? lf_r[4] : hf_r[12]) :
      (src_r == 3'h2) ? (use_lf ? lf_r[2] : hf_r[10]) :
      (src_r == 3'h3) ? hf_r[6] :
      (src_r == 3'h4) ? hf_r[2] :
      (src_r == 3'h5) ? lfp_r[10] :
      (src_r == 3'h6) ? hf_r[0] : 1'b0;
   wire slow_fc = slow & (src_r == 3'h6); // Coarse match case

   // Window gate base tick
   wire gate_tick =
      (gclk_r == 2'h0) ? (use_lf ? fs4 : fc12) :
      (gclk_r == 2'h1) ? (use_lf ? fs5 : fc13) :
      (gclk_r == 2'h2) ? (use_lf ? fs6 : fc14) : 1'b0;

   // Mode and run decode
   wire run   = (start_r == `START_RUN);
   wire meas  = (mode_r == MD_PULSE) | (mode_r == MD_FREQ);
   wire pulse = (mode_r == MD_PULSE);
   wire freq  = (mode_r == MD_FREQ);
   wire igate;                    // Internal window gate
   wire sel_gate =                // Selected window gate
      (gsrc_r == 2'h0) ? I_EXTERNAL_GATE_INPUT :
      (gsrc_r == 2'h1) ? igate :
      (gsrc_r == 2'h2) ? I_COMPANION_TIMER_OUTPUT : 1'b0;
   wire win     = pulse ? ev_s_r : sel_gate; // Event is window in pulse mode
   wire win_f   = run & win_d_r & !win;
   wire win_r   = run & !win_d_r & win;
   wire and_now = ev_s_r & (pulse ? src_lvl : sel_gate);
   wire and_f   = and_d_r & !and_now; // Fall adds extra count
   wire ev_fall = ev_d_r & !ev_s_r;   // Edge on synced event

   // Bus decode
   wire req = I_AVS_READ | I_AVS_WRITE;
   wire we  = I_AVS_WRITE & !wait_r; // Write lands when wait is low
   wire we1 = we & (I_AVS_ADDRESS == `OFF_CTRL1);
   wire we2 = we & (I_AVS_ADDRESS == `OFF_CTRL2);
   wire wec = we & (I_AVS_ADDRESS == `OFF_COMPARE);
   wire weg = we & (I_AVS_ADDRESS == `OFF_GATE);
   wire clr = we1 & I_AVS_WRITEDATA[`CLEAR_BIT];
   wire [1:0] new_start = I_AVS_WRITEDATA[3:2];
   wire stop_wr  = we1 & run & (new_start != `START_RUN);
   wire start_wr = we1 & !run & (new_start == `START_RUN);

   // Counting decode
   wire inc =
      run & ((mode_r == MD_TIMER) ? src_tick :
             (mode_r == MD_EVENT) ? ev_fall :
             and_f);
   wire [17:0] cnt_step = cnt_r + 18'h00001;
   wire hit = !meas & (slow_fc ? (cnt_step[17:11] == cmp_r[17:11])
                               : (cnt_step == cmp_r));
   wire wrap = inc & meas & (cnt_r == `CNT_MAX);
   wire irq_nxt =
      (inc & hit) |
      (meas & (win_f | (edge_r & win_r))) |
      (pulse & stop_wr & ev_s_r) |
      (pulse & start_wr & edge_r & ev_s_r);

   // Counter and overflow next values
   always_comb begin
      cnt_nxt = cnt_r;
      ovf_nxt = ovf_r | wrap; // Sticky until cleared
      if (inc) begin
         cnt_nxt = hit ? 18'h00000 : cnt_step; // Measurement keeps value
      end
      if (clr) begin // Clear zeroes both together
         cnt_nxt = 18'h00000;
         ovf_nxt = wrap; // A wrap in the clear cycle is not lost
      end
   end

   // Read mux; compare slot returns count in measurement modes
   wire [31:0] rd_mux =
      (I_AVS_ADDRESS == `OFF_CTRL1)   ? {24'h0, 1'b0, src_r, start_r, mode_r} :
      (I_AVS_ADDRESS == `OFF_CTRL2)   ?
         {25'h0, dvs_r, oblk_r, gclk_r, gsrc_r, edge_r} :
      (I_AVS_ADDRESS == `OFF_COMPARE) ? {14'h0, meas ? cnt_r : cmp_r} :
      (I_AVS_ADDRESS == `OFF_GATE)    ? {24'h0, gper_r} :
      (I_AVS_ADDRESS == `OFF_STATUS)  ? {24'h0, gact_r, ovf_r, 6'h00} :
      (I_AVS_ADDRESS == `OFF_COUNT)   ? {14'h0, cnt_r} : 32'h00000000;

   // Internal window gate sequencer
   window_gate_gen u_gate (
      .i_clk      (I_CLK_SYS),
      .i_srst     (I_SRST),
      .i_run      (run & freq & (gsrc_r == 2'h1)),
      .i_tick     (gate_tick),
      .i_high_set (gper_r[3:0]),
      .i_low_set  (gper_r[7:4]),
      .o_gate     (igate)
   );

   // Free-running dividers
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         hf_r   <= 23'h000000;
         lfp_r  <= 11'h000;
         lfen_r <= 1'b0;
         lf_r   <= 15'h0000;
      end else begin
         hf_r   <= hf_r + 23'h000001;
         lfen_r <= (lfp_r == `LF_DIV - 11'h001);
         lfp_r  <= (lfp_r == `LF_DIV - 11'h001) ? 11'h000 : lfp_r + 11'h001;
         if (lfen_r) lf_r <= lf_r + 15'h0001;
      end
   end

   // Event synchronizer and edge history
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         ev_m_r  <= 1'b0;
         ev_s_r  <= 1'b0;
         ev_d_r  <= 1'b0;
         and_d_r <= 1'b0;
         win_d_r <= 1'b0;
      end else begin
         ev_m_r  <= I_EVENT_INPUT_PIN;
         ev_s_r  <= ev_m_r;
         ev_d_r  <= ev_s_r;
         and_d_r <= and_now;
         win_d_r <= win;
      end
   end

   // Control register writes
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         mode_r  <= MD_TIMER;
         start_r <= 2'h0;
         src_r   <= 3'h0;
         edge_r  <= 1'b0;
         gsrc_r  <= 2'h0;
         gclk_r  <= 2'h0;
         oblk_r  <= 1'b0;
         dvs_r   <= 1'b0;
         cmp_r   <= `CMP_RST;
         gper_r  <= `GATE_RST;
      end else begin
         if (we1) begin
            mode_r  <= tmr_mode_e'(I_AVS_WRITEDATA[1:0]);
            start_r <= new_start;
            src_r   <= I_AVS_WRITEDATA[6:4];
         end
         if (we2) begin
            edge_r <= I_AVS_WRITEDATA[0];
            gsrc_r <= I_AVS_WRITEDATA[2:1];
            gclk_r <= I_AVS_WRITEDATA[4:3];
            oblk_r <= I_AVS_WRITEDATA[5];
            dvs_r  <= I_AVS_WRITEDATA[6];
         end
         if (wec) cmp_r <= I_AVS_WRITEDATA[17:0];
         if (weg) gper_r <= I_AVS_WRITEDATA[7:0];
      end
   end

   // Counter, flags and interrupt
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         cnt_r  <= 18'h00000;
         ovf_r  <= 1'b0;
         gact_r <= 1'b0;
         irq_r  <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         ovf_r  <= ovf_nxt;
         gact_r <= freq & run & sel_gate; // Low in pulse mode
         irq_r  <= irq_nxt;               // One-cycle pulse
      end
   end

   // Companion output routing
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         shp_r <= 1'b0;
         oe_r  <= 1'b0;
      end else begin
         shp_r <= !oblk_r & I_COMPANION_TIMER_OUTPUT;
         oe_r  <= !oblk_r;
      end
   end

   // Avalon slave: one wait cycle per access
   always_ff @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end else if (req & wait_r) begin
         wait_r  <= 1'b0;
         rdata_r <= I_AVS_READ ? rd_mux : 32'h00000000;
      end else begin
         wait_r <= 1'b1;
      end
   end

   assign O_AVS_READDATA      = rdata_r;
   assign O_AVS_WAITREQUEST   = wait_r;
   assign O_SHARED_OUTPUT_PIN = shp_r;
   assign O_SHARED_OUTPUT_OE  = oe_r;
   assign O_TIMER_INTERRUPT   = irq_r;
endmodule

// *** tmr18_checker.sv ***
`timescale 1ns/1ps
module tmr18_checker (
   input wire logic        I_CLK_SYS,                // Clock
   input wire logic        I_SRST,                   // Reset
   input wire logic [4:0]  I_AVS_ADDRESS,            // Address
   input wire logic        I_AVS_READ,               // Read
   input wire logic        I_AVS_WRITE,              // Write
   input wire logic [31:0] O_AVS_READDATA,           // Read data
   input wire logic        O_AVS_WAITREQUEST,        // Wait
   input wire logic        I_COMPANION_TIMER_OUTPUT, // Companion
   input wire logic        O_SHARED_OUTPUT_PIN,      // Shared pin
   input wire logic        O_SHARED_OUTPUT_OE,       // Pin enable
   input wire logic        O_TIMER_INTERRUPT         // Interrupt
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SRST);
   // Request seen is answered next cycle
   property p_wait_ans;
      (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("answer late");
   // Answer lasts one cycle only
   property p_wait_one;
      !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   // No request, no answer
   property p_wait_idle;
      !(I_AVS_READ || I_AVS_WRITE) |=> O_AVS_WAITREQUEST;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("answer with no request");
   // Interrupt is a single-cycle pulse
   property p_irq_pulse;
      O_TIMER_INTERRUPT |=> !O_TIMER_INTERRUPT;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than 1");
   // Outputs quiet right after reset
   property p_rst_quiet;
      $fell(I_SRST) |-> O_AVS_WAITREQUEST && !O_TIMER_INTERRUPT;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   // Enabled pin follows companion output
   property p_shared_drive;
      O_SHARED_OUTPUT_OE |-> O_SHARED_OUTPUT_PIN == $past(I_COMPANION_TIMER_OUTPUT);
   endproperty
   a_shared_drive: assert property (p_shared_drive) else $error("pin off");
   // Blocked pin stays low
   property p_shared_off;
      !O_SHARED_OUTPUT_OE |-> !O_SHARED_OUTPUT_PIN;
   endproperty
   a_shared_off: assert property (p_shared_off) else $error("pin driven");
   // Unmapped read returns zero
   property p_unmapped;
      I_AVS_READ && I_AVS_ADDRESS == 5'h18 && O_AVS_WAITREQUEST |=> O_AVS_READDATA == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   c_irq: cover property (O_TIMER_INTERRUPT);
   c_read: cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
   c_drive: cover property (O_SHARED_OUTPUT_OE && O_SHARED_OUTPUT_PIN);
endmodule
bind eighteen_bit_multimode_timer tmr18_checker chk (
   .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
   .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_READDATA(O_AVS_READDATA),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_COMPANION_TIMER_OUTPUT(I_COMPANION_TIMER_OUTPUT),
   .O_SHARED_OUTPUT_PIN(O_SHARED_OUTPUT_PIN), .O_SHARED_OUTPUT_OE(O_SHARED_OUTPUT_OE),
   .O_TIMER_INTERRUPT(O_TIMER_INTERRUPT));

// *** event_source.sv ***
`timescale 1ns/1ps
module event_source (
   input  wire logic       i_clk,  // System clock
   input  wire logic       i_srst, // Sync reset
   input  wire logic       i_go,   // Start a burst
   input  wire logic [7:0] i_n,    // Pulses in burst
   input  wire logic       i_hold, // Force pin high
   output logic            o_pin,  // Event pin
   output logic            o_busy  // Burst running
);
   logic [7:0] left_r; // Pulses still owed
   logic [3:0] ph_r;   // Phase in pulse
   logic       lvl_r;  // Pulse level
   // Each level held 8 cycles, period 16 clocks
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         left_r <= 8'h00;
         ph_r   <= 4'h0;
         lvl_r  <= 1'b0;
      end else if (i_go && left_r == 8'h00) begin
         left_r <= i_n;
         ph_r   <= 4'h0;
      end else if (left_r != 8'h00) begin
         ph_r  <= ph_r + 4'h1;
         lvl_r <= (ph_r >= 4'h7) && (ph_r != 4'hF);
         if (ph_r == 4'hF) begin
            left_r <= left_r - 8'h01;
         end
      end
   end
   assign o_pin  = lvl_r | i_hold; // Idles low between bursts
   assign o_busy = left_r != 8'h00;
endmodule

// *** eighteen_bit_multimode_timer_tb_top.sv ***
`timescale 1ns/1ps
`include "tmr18_consts.svh"
module eighteen_bit_multimode_timer_tb_top;
   import tmr18_pkg::*;
   logic        clk, srst, rd_en, wr_en, gate, comp, go, hold; // Bench drives
   logic [4:0]  addr;            // Bus address
   logic [31:0] wdata, q, v;     // Write, read data
   logic        wt, sh, oe, irq; // Design outputs
   logic        pin, busy;       // Partner lines
   logic [7:0]  npulse;          // Burst length
   pwr_mode_e   pwr;             // Power mode
   int          n_mismatch, comparisons, n_irq, cyc, i0, c;
   eighteen_bit_multimode_timer uut (.I_CLK_SYS(clk), .I_SRST(srst), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(q),
      .O_AVS_WAITREQUEST(wt), .I_PWR_MODE(pwr), .I_EVENT_INPUT_PIN(pin),
      .I_EXTERNAL_GATE_INPUT(gate), .I_COMPANION_TIMER_OUTPUT(comp),
      .O_SHARED_OUTPUT_PIN(sh), .O_SHARED_OUTPUT_OE(oe), .O_TIMER_INTERRUPT(irq));
   event_source src (.i_clk(clk), .i_srst(srst), .i_go(go), .i_n(npulse), .i_hold(hold),
      .o_pin(pin), .o_busy(busy));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   // Interrupt tally, cycle limit, companion toggling
   always @(posedge clk) begin
      n_irq += (irq === 1'b1);
      cyc++;
      comp <= ~comp;
      if (cyc == 100000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task check(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // One Avalon access held until waitrequest low
   task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      rd_en <= !w;
      wr_en <= w;
      addr  <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         t++;
      end while (wt !== 1'b0 && t < 50);
      v = q;
      rd_en <= 0;
      wr_en <= 0;
      if (t >= 50) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   // Burst of event pulses from the partner
   task pulses(input int k);
      int t;
      t = 0;
      @(posedge clk);
      go     <= 1;
      npulse <= 8'(k);
      @(posedge clk);
      go <= 0;
      do begin
         @(posedge clk);
         t++;
      end while (busy === 1'b1 && t < 5000);
      repeat (6) @(posedge clk);
   endtask
   // Cycles until the next interrupt pulse
   task wirq(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq !== 1'b1 && n < 20000);
   endtask
   function logic [31:0] ctl(input logic [1:0] m, input logic r, input logic [2:0] s,
                             input logic k);
      return {24'h0, k, s, r, 1'b0, m};
   endfunction
   initial begin
      {srst, rd_en, wr_en, gate, comp, go, hold, addr, wdata, npulse} = '0;
      srst = 1;
      pwr  = PWR_NORMAL;
      repeat (16) @(posedge clk);
      srst <= 0;
      repeat (3) @(posedge clk);
      check("oe", oe, 1);
      check("pin drive", sh, !comp);
      acc(1, `OFF_CTRL2, 32'h20);
      repeat (3) @(posedge clk);
      check("oe blocked", oe, 0);
      check("pin blocked", sh, 0);
      acc(0, 5'h18, 0);
      check("unmapped", v, 0);
      // Timer mode, fc source, compare 5, then slow power with compare 0x807
      acc(1, `OFF_COMPARE, 5);
      acc(1, `OFF_CTRL1, ctl(0, 1, 6, 0));
      wirq(c);
      wirq(c);
      check("timer period", c, 5);
      acc(1, `OFF_CTRL1, ctl(0, 0, 6, 1));
      pwr <= PWR_SLOW;
      acc(1, `OFF_COMPARE, 32'h807);
      acc(1, `OFF_CTRL1, ctl(0, 1, 6, 1));
      wirq(c);
      wirq(c);
      check("slow period", c, 2048);
      acc(1, `OFF_CTRL1, ctl(0, 0, 6, 1));
      pwr <= PWR_NORMAL;
      // Event counter, compare 3
      acc(1, `OFF_COMPARE, 3);
      acc(1, `OFF_CTRL1, ctl(1, 1, 7, 1));
      i0 = n_irq;
      pulses(2);
      acc(0, `OFF_COUNT, 0);
      check("event count", v, 2);
      pulses(4);
      check("event irqs", n_irq - i0, 2);
      acc(0, `OFF_COUNT, 0);
      check("event cleared", v, 0);
      // Frequency mode, pin gate, falling edge, then both edges
      acc(1, `OFF_CTRL1, ctl(1, 0, 7, 1));
      acc(1, `OFF_CTRL2, 0);
      acc(1, `OFF_CTRL1, ctl(3, 1, 7, 1));
      gate <= 1;
      acc(0, `OFF_STATUS, 0);
      check("gate active", v[7], 1);
      i0 = n_irq;
      pulses(4);
      gate <= 0;
      repeat (8) @(posedge clk);
      check("fall irq", n_irq - i0, 1);
      acc(0, `OFF_COUNT, 0);
      check("freq count", v, 4);
      acc(0, `OFF_STATUS, 0);
      check("gate low", v[7], 0);
      gate <= 1;
      pulses(2);
      gate <= 0;
      repeat (8) @(posedge clk);
      acc(0, `OFF_COUNT, 0);
      check("accumulate", v, 6);
      acc(1, `OFF_CTRL1, ctl(3, 1, 7, 1));
      acc(0, `OFF_STATUS, 0);
      check("ovf clear", v[6], 0);
      hold <= 1;
      gate <= 1;
      repeat (8) @(posedge clk);
      gate <= 0;
      repeat (8) @(posedge clk);
      hold <= 0;
      acc(0, `OFF_COUNT, 0);
      check("gate fall extra", v, 1);
      acc(1, `OFF_CTRL1, ctl(3, 0, 7, 0));
      acc(1, `OFF_CTRL2, 1);
      acc(1, `OFF_CTRL1, ctl(3, 1, 7, 0));
      i0 = n_irq;
      gate <= 1;
      repeat (8) @(posedge clk);
      check("rise irq", n_irq - i0, 1);
      gate <= 0;
      // Pulse width, both edges, pin high at start and stop
      acc(1, `OFF_CTRL1, ctl(2, 0, 4, 1));
      hold <= 1;
      repeat (6) @(posedge clk);
      i0 = n_irq;
      acc(1, `OFF_CTRL1, ctl(2, 1, 4, 0));
      repeat (4) @(posedge clk);
      check("start irq", n_irq - i0, 1);
      i0 = n_irq;
      acc(1, `OFF_CTRL1, ctl(2, 0, 4, 0));
      repeat (4) @(posedge clk);
      check("stop irq", n_irq - i0, 1);
      hold <= 0;
      // Internal gate: high 2, low 1 base periods of 4096
      acc(1, `OFF_CTRL1, ctl(3, 0, 7, 1));
      acc(1, `OFF_GATE, 32'hFE);
      acc(1, `OFF_CTRL2, 3);
      acc(1, `OFF_CTRL1, ctl(3, 1, 7, 1));
      wirq(c);
      wirq(c);
      check("gate high", c, 8192);
      wirq(c);
      check("gate low", c, 4096);
      finish_test();
   end
endmodule
